// >>> rtl/icg_clock_gen.v
`timescale 1ns/10ps
`include "icg_consts.vh"

module icg_clock_gen (
  // apb slave, pclk is the base system clock straight from the oscillator
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // external clock pin and phase detect mode
  input  wire        servo_pin_clock,
  input  wire        phase_mode,
  // core and bus clocks
  output reg         bus_clock,
  output reg         core_phase_one,
  output reg         core_phase_two,
  // fixed peripheral clocks
  output reg         diag_shift_clock,
  output reg         spin_capture_clock,
  output reg         analog_refresh_clock,
  // programmable clocks
  output reg         external_output_clock,
  output reg         servo_sequencer_clock,
  output reg         secondary_servo_clock,
  output reg         phase_detect_clock,
  output reg         serial_master_clock,
  output reg         acquisition_sample_clock,
  output reg         shock_sensor_clock,
  output reg         coarse_compare_clock,
  output reg         fine_compare_clock
);

  // ************************************************************
  // helpers
  // ************************************************************
  // high for the first half of a divide-by-(lim+1) cycle
  function high_half;
    input [4:0] cnt;
    input [4:0] lim;
    begin
      high_half = (cnt <= (lim >> 1));
    end
  endfunction

  // last count of a divide-by-(lim+1) cycle
  function at_end;
    input [4:0] cnt;
    input [4:0] lim;
    begin
      at_end = (cnt >= lim);
    end
  endfunction

  // wrapping count step
  function [4:0] step;
    input [4:0] cnt;
    input [4:0] lim;
    begin
      if (cnt >= lim) begin
        step = 5'h00;
      end else begin
        step = cnt + 5'h01;
      end
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg  [15:0] cfg_one_reg;
  reg  [15:0] cfg_two_reg;
  reg         pin_meta_reg;
  reg         pin_sync_reg;
  reg         pin_last_reg;

  wire        pin_rise = pin_sync_reg & ~pin_last_reg;
  wire        bus_tick = bus_clock;
  wire        setup    = psel & ~penable;
  wire        do_write = psel & penable & pready & pwrite & ~pslverr;

  // live clock levels for the status register
  wire [15:0] status_word;

  assign status_word[0]     = bus_clock;
  assign status_word[1]     = core_phase_one;
  assign status_word[2]     = core_phase_two;
  assign status_word[3]     = diag_shift_clock;
  assign status_word[4]     = spin_capture_clock;
  assign status_word[5]     = analog_refresh_clock;
  assign status_word[6]     = external_output_clock;
  assign status_word[7]     = servo_sequencer_clock;
  assign status_word[8]     = secondary_servo_clock;
  assign status_word[9]     = serial_master_clock;
  assign status_word[10]    = acquisition_sample_clock;
  assign status_word[11]    = coarse_compare_clock;
  assign status_word[12]    = phase_detect_clock;
  assign status_word[15:13] = 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup) begin
        if (paddr == `ICG_OFF_CFG_ONE) begin
          prdata <= {16'h0000, cfg_one_reg};
        end else if (paddr == `ICG_OFF_CFG_TWO) begin
          prdata <= {16'h0000, cfg_two_reg};
        end else if (paddr == `ICG_OFF_STATUS) begin
          prdata <= {16'h0000, status_word};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_one_reg <= `ICG_CFG1_RESET;
      cfg_two_reg <= `ICG_CFG2_RESET;
    end else if (do_write) begin
      if (paddr == `ICG_OFF_CFG_ONE) begin
        cfg_one_reg <= pwdata[15:0] & `ICG_CFG1_WMASK;
      end else if (paddr == `ICG_OFF_CFG_TWO) begin
        cfg_two_reg <= pwdata[15:0] & `ICG_CFG2_WMASK;
      end
    end
  end

  // ************************************************************
  // servo pin synchroniser
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= servo_pin_clock;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  // ************************************************************
  // bus clock and fixed dividers
  // ************************************************************
  reg  [1:0]  spin_cnt_reg;
  reg  [5:0]  refresh_cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clock            <= 1'b0;
      core_phase_one       <= 1'b0;
      core_phase_two       <= 1'b0;
      diag_shift_clock     <= 1'b0;
      spin_capture_clock   <= 1'b0;
      analog_refresh_clock <= 1'b0;
      spin_cnt_reg         <= 2'h0;
      refresh_cnt_reg      <= 6'h00;
    end else begin
      bus_clock      <= ~bus_clock;
      core_phase_one <= ~bus_clock;
      core_phase_two <= bus_clock;
      if (bus_tick) begin
        diag_shift_clock <= ~diag_shift_clock;
        if (spin_cnt_reg == `ICG_SPIN_HALF) begin
          spin_cnt_reg       <= 2'h0;
          spin_capture_clock <= ~spin_capture_clock;
        end else begin
          spin_cnt_reg <= spin_cnt_reg + 2'h1;
        end
        if (refresh_cnt_reg == `ICG_REFRESH_HALF) begin
          refresh_cnt_reg      <= 6'h00;
          analog_refresh_clock <= ~analog_refresh_clock;
        end else begin
          refresh_cnt_reg <= refresh_cnt_reg + 6'h01;
        end
      end
    end
  end

  // ************************************************************
  // programmable dividers
  // ************************************************************
  reg  [4:0]  ext_cnt_reg;
  reg  [4:0]  ext_lim_reg;
  reg  [4:0]  seq_cnt_reg;
  reg  [4:0]  seq_lim_reg;
  reg         seq_sel_reg;
  reg  [4:0]  sec_cnt_reg;
  reg  [4:0]  sec_lim_reg;
  reg  [4:0]  ser_cnt_reg;
  reg  [4:0]  ser_lim_reg;
  reg  [4:0]  acq_cnt_reg;
  reg  [4:0]  acq_lim_reg;
  reg  [2:0]  pw_cnt_reg;
  reg  [2:0]  pw_lim_reg;

  // selected sequencer source tick
  wire        seq_src  = seq_sel_reg ? pin_rise : 1'b1;
  wire        seq_tick = seq_src & at_end(seq_cnt_reg, seq_lim_reg);
  wire        acq_end  = bus_tick & at_end(acq_cnt_reg, acq_lim_reg);
  wire        ext_end  = at_end(ext_cnt_reg, ext_lim_reg);
  wire        sec_end  = at_end(sec_cnt_reg, sec_lim_reg);
  wire        ser_end  = at_end(ser_cnt_reg, ser_lim_reg);

  // next counts of the programmable dividers
  wire [4:0]  ext_cnt_next = step(ext_cnt_reg, ext_lim_reg);
  wire [4:0]  seq_cnt_next = step(seq_cnt_reg, seq_lim_reg);
  wire [4:0]  sec_cnt_next = step(sec_cnt_reg, sec_lim_reg);
  wire [4:0]  ser_cnt_next = step(ser_cnt_reg, ser_lim_reg);
  wire [4:0]  acq_cnt_next = step(acq_cnt_reg, acq_lim_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_reg <= 5'h00;
      ext_lim_reg <= 5'h00;
      external_output_clock <= 1'b0;
    end else begin
      ext_cnt_reg <= ext_cnt_next;
      if (ext_end) begin
        ext_lim_reg <= cfg_one_reg[12:8];
      end
      external_output_clock <= high_half(ext_cnt_next, ext_lim_reg);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt_reg           <= 5'h00;
      seq_lim_reg           <= 5'h00;
      seq_sel_reg           <= 1'b0;
      servo_sequencer_clock <= 1'b0;
    end else begin
      if (seq_src) begin
        seq_cnt_reg           <= seq_cnt_next;
        servo_sequencer_clock <= high_half(seq_cnt_next, seq_lim_reg);
      end
      if (seq_tick) begin
        seq_lim_reg <= {1'b0, cfg_one_reg[3:0]};
        seq_sel_reg <= cfg_one_reg[`ICG_CFG1_SEQ_SEL];
      end
    end
  end

  // secondary divider steps once per sequencer period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_reg           <= 5'h00;
      sec_lim_reg           <= 5'h00;
      secondary_servo_clock <= 1'b0;
    end else if (seq_tick) begin
      sec_cnt_reg           <= sec_cnt_next;
      secondary_servo_clock <= high_half(sec_cnt_next, sec_lim_reg);
      if (sec_end) begin
        sec_lim_reg <= {1'b0, cfg_one_reg[7:4]};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_detect_clock <= 1'b0;
    end else if (phase_mode) begin
      phase_detect_clock <= cfg_one_reg[`ICG_CFG1_PHASE_SEL] ? pin_sync_reg : 1'b1;
    end else begin
      phase_detect_clock <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_cnt_reg         <= 5'h00;
      ser_lim_reg         <= 5'h00;
      serial_master_clock <= 1'b0;
    end else begin
      if (bus_tick) begin
        ser_cnt_reg <= ser_cnt_next;
        if (ser_end) begin
          ser_lim_reg <= {1'b0, cfg_two_reg[11:8]};
        end
      end
      // divide by one runs at the bus clock rate itself
      if (ser_lim_reg == 5'h00) begin
        serial_master_clock <= ~bus_clock;
      end else if (bus_tick) begin
        serial_master_clock <= high_half(ser_cnt_next, ser_lim_reg);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_cnt_reg <= 5'h00;
      acq_lim_reg <= 5'h00;
      pw_cnt_reg  <= 3'h0;
      pw_lim_reg  <= 3'h0;
      acquisition_sample_clock <= 1'b0;
      shock_sensor_clock       <= 1'b0;
      coarse_compare_clock     <= 1'b0;
      fine_compare_clock       <= 1'b0;
    end else if (bus_tick) begin
      acq_cnt_reg <= acq_cnt_next;
      if (acq_end) begin
        acq_lim_reg <= cfg_two_reg[4:0];
        acquisition_sample_clock <= ~acquisition_sample_clock;
        shock_sensor_clock       <= ~acquisition_sample_clock;
      end
      // compare pulse opens on the acquisition rising edge
      if (acq_end & ~acquisition_sample_clock) begin
        pw_cnt_reg <= 3'h0;
        pw_lim_reg <= cfg_two_reg[7:5];
        coarse_compare_clock <= 1'b1;
        fine_compare_clock   <= 1'b1;
      end else if (coarse_compare_clock) begin
        if (pw_cnt_reg >= pw_lim_reg) begin
          coarse_compare_clock <= 1'b0;
          fine_compare_clock   <= 1'b0;
        end else begin
          pw_cnt_reg <= pw_cnt_reg + 3'h1;
        end
      end
    end
  end

endmodule // icg_clock_gen

// >>> common/icg_consts.vh
`ifndef ICG_CONSTS_VH
`define ICG_CONSTS_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define ICG_ADDR_W          12
`define ICG_OFF_CFG_ONE     12'h000
`define ICG_OFF_CFG_TWO     12'h004
`define ICG_OFF_STATUS      12'h008

// ************************************************************
// field positions and masks
// ************************************************************
`define ICG_CFG1_PHASE_SEL  15
`define ICG_CFG1_SEQ_SEL    14
`define ICG_CFG1_WMASK      16'hdfff
`define ICG_CFG2_WMASK      16'h0fff
`define ICG_CFG1_RESET      16'h0000
`define ICG_CFG2_RESET      16'h0000

// ************************************************************
// fixed division counts, bus clock cycles per half period less one
// ************************************************************
`define ICG_SPIN_HALF       2'h3
`define ICG_REFRESH_HALF    6'h29

`endif

// >>> verification/icg_clock_gen_chk.sv
`timescale 1ns/10ps
// ************************************************************
// port checks for the clock generator
// ************************************************************
module icg_clock_gen_chk (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // clocks
  input wire        phase_mode,
  input wire        bus_clock,
  input wire        core_phase_one,
  input wire        core_phase_two,
  input wire        diag_shift_clock,
  input wire        spin_capture_clock,
  input wire        phase_detect_clock,
  input wire        acquisition_sample_clock,
  input wire        shock_sensor_clock,
  input wire        coarse_compare_clock,
  input wire        fine_compare_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bus_half: assert property (bus_clock |=> !bus_clock ##1 bus_clock)
    else $error("bus clock not half rate");
  a_phase_align: assert property ($past(presetn) |->
    core_phase_one == bus_clock && core_phase_two == !bus_clock)
    else $error("core phases not aligned to bus clock");
  a_diag_rate: assert property ($rose(diag_shift_clock) |=> diag_shift_clock ##1
    !diag_shift_clock[*2] ##1 diag_shift_clock) else $error("diag shift rate wrong");
  a_spin_rate: assert property ($rose(spin_capture_clock) |=> spin_capture_clock[*7] ##1
    !spin_capture_clock[*8] ##1 spin_capture_clock) else $error("spin capture rate wrong");
  a_phase_off: assert property (!phase_mode[*3] |-> !phase_detect_clock)
    else $error("phase detect clock outside phase mode");
  a_cmp_twin: assert property (fine_compare_clock == coarse_compare_clock &&
    shock_sensor_clock == acquisition_sample_clock) else $error("twin clocks differ");
  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_err_unmap: assert property (psel && !penable && paddr == 12'h00c |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_resv_one: assert property (pready && !pwrite && paddr == 12'h000 |->
    prdata[13] == 1'b0 && prdata[31:16] == 16'h0000) else $error("cfg one reserved bit set");
  a_resv_two: assert property (pready && !pwrite && paddr == 12'h004 |->
    prdata[31:12] == 20'h00000) else $error("cfg two reserved bits set");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside access");
endmodule // icg_clock_gen_chk

bind icg_clock_gen icg_clock_gen_chk icg_clock_gen_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phase_mode(phase_mode), .bus_clock(bus_clock),
  .core_phase_one(core_phase_one), .core_phase_two(core_phase_two),
  .diag_shift_clock(diag_shift_clock), .spin_capture_clock(spin_capture_clock),
  .phase_detect_clock(phase_detect_clock), .acquisition_sample_clock(acquisition_sample_clock),
  .shock_sensor_clock(shock_sensor_clock), .coarse_compare_clock(coarse_compare_clock),
  .fine_compare_clock(fine_compare_clock));

// >>> verification/tb_icg_clock_gen.sv
`timescale 1ns/10ps
`include "icg_consts.vh"
module tb_icg_clock_gen;
  logic        pclk, presetn, psel, penable, pwrite, servo_pin_clock, phase_mode, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, bus_clock, core_phase_one, core_phase_two, diag_shift_clock;
  logic        spin_capture_clock, analog_refresh_clock, external_output_clock;
  logic        servo_sequencer_clock, secondary_servo_clock, phase_detect_clock;
  logic        serial_master_clock, acquisition_sample_clock, shock_sensor_clock;
  logic        coarse_compare_clock, fine_compare_clock;
  wire  [13:0] clks;
  int          errors = 0, num_checks = 0, pin_cnt = 0;
  logic [15:0] c1_tab [3] = '{16'h0111, 16'h1f2f, 16'h04f2};
  logic [15:0] c2_tab [3] = '{16'h0101, 16'h0fff, 16'h0064};

  assign clks = {fine_compare_clock, coarse_compare_clock, shock_sensor_clock,
    acquisition_sample_clock, serial_master_clock, phase_detect_clock, secondary_servo_clock,
    servo_sequencer_clock, external_output_clock, analog_refresh_clock, spin_capture_clock,
    diag_shift_clock, core_phase_one, bus_clock};

  icg_clock_gen icg_clock_gen_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servo_pin_clock(servo_pin_clock),
    .phase_mode(phase_mode), .bus_clock(bus_clock), .core_phase_one(core_phase_one),
    .core_phase_two(core_phase_two), .diag_shift_clock(diag_shift_clock),
    .spin_capture_clock(spin_capture_clock), .analog_refresh_clock(analog_refresh_clock),
    .external_output_clock(external_output_clock),
    .servo_sequencer_clock(servo_sequencer_clock),
    .secondary_servo_clock(secondary_servo_clock), .phase_detect_clock(phase_detect_clock),
    .serial_master_clock(serial_master_clock),
    .acquisition_sample_clock(acquisition_sample_clock),
    .shock_sensor_clock(shock_sensor_clock), .coarse_compare_clock(coarse_compare_clock),
    .fine_compare_clock(fine_compare_clock));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // servo pin at one eighth of pclk
  always @(posedge pclk) begin
    pin_cnt <= (pin_cnt + 1) % 4;
    if (pin_cnt == 3) servo_pin_clock <= ~servo_pin_clock;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // period, or high width when hi, from the second rise on
  task automatic per(input string nm, input int i, input logic hi, input int exp);
    int n, c, ta, t;
    logic p;
    c = 0; t = -1; ta = 0; p = clks[i];
    for (n = 0; n < 2000 && c < 3; n++) begin
      @(negedge pclk);
      if (p === 1'b0 && clks[i] === 1'b1) begin
        c++;
        if (c == 2) ta = n;
        if (c == 3 && !hi) t = n - ta;
      end
      if (hi && c == 2 && p === 1'b1 && clks[i] === 1'b0) begin t = n - ta; c = 3; end
      p = clks[i];
    end
    chk(nm, exp, t);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    apb(0, `ICG_OFF_CFG_ONE, 0); chk("cfg one reset", 0, rd);
    apb(0, `ICG_OFF_CFG_TWO, 0); chk("cfg two reset", 0, rd);
    apb(1, `ICG_OFF_CFG_ONE, 32'hffffffff);
    apb(1, `ICG_OFF_CFG_TWO, 32'hffffffff);
    apb(0, `ICG_OFF_CFG_ONE, 0); chk("cfg one rw", 32'h0000dfff, rd);
    apb(0, `ICG_OFF_CFG_TWO, 0); chk("cfg two rw", 32'h00000fff, rd);
    apb(1, 12'h00c, 0); chk("unmapped err", 1, er);
    apb(0, `ICG_OFF_STATUS, 0); chk("status err", 0, er);
    chk("status spare", 0, rd[31:13]);
    apb(1, `ICG_OFF_CFG_ONE, 0);
    apb(1, `ICG_OFF_CFG_TWO, 0);
  endtask

  task t_fixed;
    per("bus", 0, 0, 2);
    per("phase one high", 1, 1, 1);
    per("diag", 2, 0, 4);
    per("spin", 3, 0, 16);
    per("refresh", 4, 0, 168);
  endtask

  task t_prog;
    for (int k = 0; k < 3; k++) begin
      apb(1, `ICG_OFF_CFG_ONE, {16'h0000, c1_tab[k]});
      apb(1, `ICG_OFF_CFG_TWO, {16'h0000, c2_tab[k]});
      per("external", 5, 0, c1_tab[k][12:8] + 1);
      per("sequencer", 6, 0, c1_tab[k][3:0] + 1);
      per("secondary", 7, 0, (c1_tab[k][7:4] + 1) * (c1_tab[k][3:0] + 1));
      per("serial", 9, 0, 2 * (c2_tab[k][11:8] + 1));
      per("acquisition", 10, 0, 4 * (c2_tab[k][4:0] + 1));
      per("shock", 11, 0, 4 * (c2_tab[k][4:0] + 1));
      per("compare high", 12, 1, 2 * (c2_tab[k][7:5] + 1));
      per("compare rate", 13, 0, 4 * (c2_tab[k][4:0] + 1));
    end
  endtask

  task t_servo;
    apb(1, `ICG_OFF_CFG_ONE, 32'h0000c001);
    per("pin sequencer", 6, 0, 16);
    @(posedge pclk);
    phase_mode <= 1'b1;
    per("pin phase", 8, 0, 8);
    apb(1, `ICG_OFF_CFG_ONE, 32'h00000001);
    per("sys sequencer", 6, 0, 2);
    chk("sys phase", 1, phase_detect_clock);
    @(posedge pclk);
    phase_mode <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("phase off", 0, phase_detect_clock);
  endtask

  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("reset bus", 0, bus_clock);
    presetn <= 1'b1;
    apb(0, `ICG_OFF_CFG_ONE, 0); chk("cfg one rereset", 0, rd);
    per("bus again", 0, 0, 2);
  endtask

  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    servo_pin_clock = 0; phase_mode = 0; presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_fixed;
    t_prog;
    t_servo;
    t_reset;
    results;
  end

  // about 40000 cycles, several times the expected run
  initial begin
    #200000;
    errors++;
    results;
  end
endmodule // tb_icg_clock_gen
